// ---- hw/fcb_pkg.sv ----
// fcb_pkg: constants, timing counts and types for the flash bus controller.
// assumes one 125 MHz clock (mclk) and a clockless parallel flash outside.
`default_nettype none

package fcb_pkg;

   ////////////////////////////////////////////////////////////////////////
   // timing; the cycle counts are derived from the clock period
   localparam int CLK_PERIOD_NS = 8;
   localparam int T_ACC_NS = 100;
   localparam int T_WP_NS = 50;
   localparam int T_AS_NS = 10;
   localparam int T_AH_NS = 10;
   localparam int T_RP_NS = 500;
   localparam int T_RH_NS = 50;
   localparam int T_BUSY_NS = 100;
   // least times round up
   localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int AS_CYC = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int AH_CYC = (T_AH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RH_CYC = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_CYC = (T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STAGES = 2;

   ////////////////////////////////////////////////////////////////////////
   // widths and field positions
   localparam int ADDR_W = 19;
   localparam int UADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int CNT_W = 8;
   localparam int TMO_W = 32;
   localparam int STEP_W = 3;
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int TOP_BIT = 15;

   // output enables, low bit = lane driven
   localparam logic [DATA_W-1:0] OE_NONE = 16'hFFFF;
   localparam logic [DATA_W-1:0] OE_WORD_WR = 16'h0000;
   localparam logic [DATA_W-1:0] OE_BYTE_WR = 16'h7F00;
   localparam logic [DATA_W-1:0] OE_BYTE_RD = 16'h7FFF;
   localparam logic [TOP_BIT-BYTE_W-1:0] MID_ZERO = 7'h00;

   ////////////////////////////////////////////////////////////////////////
   // operations the user may order
   typedef enum logic [3:0] {
      OP_READ = 4'h0,
      OP_PROGRAM = 4'h1,
      OP_BYP_PROGRAM = 4'h2,
      OP_ERASE_SECT = 4'h3,
      OP_ERASE_CHIP = 4'h4,
      OP_SUSPEND = 4'h5,
      OP_RESUME = 4'h6,
      OP_BYP_ENTER = 4'h7,
      OP_BYP_EXIT = 4'h8,
      OP_WAIT = 4'h9,
      OP_RESET = 4'hA
   } fcb_op_t;

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_ISSUE = 8'h02,
      ST_CYC = 8'h04,
      ST_SETTLE = 8'h08,
      ST_WAITRB = 8'h10,
      ST_RSTLO = 8'h20,
      ST_RSTREC = 8'h40,
      ST_RESP = 8'h80
   } fcb_state_t;

   typedef enum logic [4:0] {
      CY_IDLE = 5'h01,
      CY_SETUP = 5'h02,
      CY_PULSE = 5'h04,
      CY_HOLD = 5'h08,
      CY_DONE = 5'h10
   } fcb_cy_state_t;

   // one bus write of a command sequence
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic fromUser;
   } fcb_cyc_t;

   typedef struct packed {
      logic chipSel_n;
      logic outEn_n;
      logic wrEn_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dataOut;
      logic [DATA_W-1:0] dataOe_n;
   } fcb_pins_t;

   localparam fcb_pins_t PINS_IDLE = '{
      chipSel_n: 1'b1, outEn_n: 1'b1, wrEn_n: 1'b1,
      addr: '0, dataOut: '0, dataOe_n: OE_NONE};

endpackage : fcb_pkg

`default_nettype wire

// ---- hw/fcb_cycle.sv ----
// fcb_cycle: one asynchronous read or write cycle on the flash pins.
// assumes start only while idle; data lines arrive from outside the clock.
`default_nettype none

module fcb_cycle
   import fcb_pkg::*;
#(
   parameter int SETUP_CYC = AS_CYC,
   parameter int PULSE_CYC = WP_CYC,
   parameter int READ_CYC = ACC_CYC,
   parameter int HOLD_CYC = AH_CYC
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic isWrite,
   input wire logic byteMode,
   input wire logic byteLsb,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [DATA_W-1:0] dataIn,
   output var fcb_pins_t pins,
   output logic [DATA_W-1:0] rdata,
   output logic done
);

   typedef struct packed {
      fcb_cy_state_t st;
      logic [CNT_W-1:0] cnt;
      logic wr;
      fcb_pins_t pins;
      logic [DATA_W-1:0] dS1;
      logic [DATA_W-1:0] dS2;
      logic [DATA_W-1:0] rdata;
   } fcb_cy_reg_t;

   fcb_cy_reg_t r_r;
   fcb_cy_reg_t r_nxt;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      r_nxt = r_r;
      r_nxt.dS1 = dataIn;
      r_nxt.dS2 = r_r.dS1;
      unique case (r_r.st)
         CY_IDLE: begin
            if (start) begin
               r_nxt.wr = isWrite;
               r_nxt.pins.chipSel_n = 1'b0;
               r_nxt.pins.addr = addr;
               // byte mode: top line carries the byte address bit
               r_nxt.pins.dataOut = byteMode ?
                  {byteLsb, MID_ZERO, wdata[BYTE_W-1:0]} : wdata;
               r_nxt.pins.dataOe_n = isWrite ?
                  (byteMode ? OE_BYTE_WR : OE_WORD_WR) :
                  (byteMode ? OE_BYTE_RD : OE_NONE);
               r_nxt.cnt = CNT_W'(SETUP_CYC - 1);
               r_nxt.st = CY_SETUP;
            end
         end
         CY_SETUP: begin
            if (r_r.cnt == '0) begin
               // a write is an ordinary strobe cycle; a read keeps we high
               r_nxt.pins.wrEn_n = ~r_r.wr;
               r_nxt.pins.outEn_n = r_r.wr;
               r_nxt.cnt = r_r.wr ? CNT_W'(PULSE_CYC - 1) :
                  CNT_W'(READ_CYC + SYNC_STAGES - 1);
               r_nxt.st = CY_PULSE;
            end else begin
               r_nxt.cnt = r_r.cnt - 1'b1;
            end
         end
         CY_PULSE: begin
            if (r_r.cnt == '0) begin
               r_nxt.pins.wrEn_n = 1'b1;
               r_nxt.pins.outEn_n = 1'b1;
               // synchroniser delay is paid inside the strobe
               if (!r_r.wr) begin
                  r_nxt.rdata = r_r.dS2;
               end
               r_nxt.cnt = CNT_W'(HOLD_CYC - 1);
               r_nxt.st = CY_HOLD;
            end else begin
               r_nxt.cnt = r_r.cnt - 1'b1;
            end
         end
         CY_HOLD: begin
            if (r_r.cnt == '0) begin
               // deselect between cycles puts the part in standby
               r_nxt.pins.chipSel_n = 1'b1;
               r_nxt.pins.dataOe_n = OE_NONE;
               r_nxt.st = CY_DONE;
            end else begin
               r_nxt.cnt = r_r.cnt - 1'b1;
            end
         end
         CY_DONE: begin
            r_nxt.st = CY_IDLE;
         end
         default: begin
            r_nxt.st = CY_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         r_r <= '{st: CY_IDLE, cnt: '0, wr: 1'b0, pins: PINS_IDLE,
                  dS1: '0, dS2: '0, rdata: '0};
      end else begin
         r_r <= r_nxt;
      end
   end

   assign pins = r_r.pins;
   assign rdata = r_r.rdata;
   assign done = (r_r.st == CY_DONE);

endmodule : fcb_cycle

`default_nettype wire

// ---- hw/fcb_host.sv ----
// fcb_host: controller that drives the parallel flash through its pins.
// assumes a user side that waits for reqReady; the flash has no clock.
//
// Notes on behaviour
// - commands are plain write cycles; the flash state machine runs them.
// - in unlock bypass a program needs two writes, not four.
// - completion shows on ready/busy pin or on polling and toggle bits.
// - the host may deselect the flash into standby when idle.
// - in byte mode the host drives the top line with byte address.
// - reads drive chip select and output enable low, write enable high.
`default_nettype none

module fcb_host
   import fcb_pkg::*;
#(
   // common command words; override them for a part that differs
   parameter logic [ADDR_W-1:0] UNLOCK_ADDR_A = 19'h0_0555,
   parameter logic [ADDR_W-1:0] UNLOCK_ADDR_B = 19'h0_02AA,
   parameter logic [DATA_W-1:0] UNLOCK_DATA_A = 16'h00AA,
   parameter logic [DATA_W-1:0] UNLOCK_DATA_B = 16'h0055,
   parameter logic [DATA_W-1:0] PROGRAM_CODE = 16'h00A0,
   parameter logic [DATA_W-1:0] ERASE_SETUP_CODE = 16'h0080,
   parameter logic [DATA_W-1:0] SECTOR_ERASE_CODE = 16'h0030,
   parameter logic [DATA_W-1:0] CHIP_ERASE_CODE = 16'h0010,
   parameter logic [DATA_W-1:0] SUSPEND_CODE = 16'h00B0,
   parameter logic [DATA_W-1:0] RESUME_CODE = 16'h0030,
   parameter logic [DATA_W-1:0] BYPASS_CODE = 16'h0020,
   parameter logic [DATA_W-1:0] BYPASS_EXIT_A = 16'h0090,
   parameter logic [DATA_W-1:0] BYPASS_EXIT_B = 16'h0000,
   parameter int OP_TIMEOUT_CYC = 32'h0773_5940
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic reqValid,
   output logic reqReady,
   input wire fcb_op_t reqOp,
   input wire logic [UADDR_W-1:0] reqAddr,
   input wire logic [DATA_W-1:0] reqData,
   input wire logic cfgByteMode,
   input wire logic cfgUsePoll,
   output logic respDone,
   output logic respErr,
   output logic [DATA_W-1:0] respData,
   output logic busy,
   output logic flash_chip_select_n,
   output logic flash_output_enable_n,
   output logic flash_write_enable_n,
   output logic flashReset_n,
   output logic width_select_pin,
   output logic [ADDR_W-1:0] flashAddr,
   output logic [DATA_W-1:0] flashDataOut,
   output logic [DATA_W-1:0] flashDataOe_n,
   input wire logic [DATA_W-1:0] flashDataIn,
   input wire logic ready_busy_out
);

   typedef struct packed {
      fcb_state_t st;
      fcb_op_t op;
      logic [STEP_W-1:0] step;
      logic [UADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic byteMode;
      logic usePoll;
      logic isPoll;
      logic havePrev;
      logic [DATA_W-1:0] prev;
      logic [TMO_W-1:0] cnt;
      logic rbS1;
      logic rbS2;
      logic err;
      logic [DATA_W-1:0] rdData;
      logic rstN;
   } fcb_reg_t;

   fcb_reg_t r_r;
   fcb_reg_t r_nxt;
   fcb_cyc_t cyc;
   fcb_pins_t pins;
   logic cycStart;
   logic cycWrite;
   logic cycDone;
   logic cycLsb;
   logic [ADDR_W-1:0] cycAddr;
   logic [ADDR_W-1:0] userPinAddr;
   logic [DATA_W-1:0] cycRdata;
   logic [DATA_W-1:0] cycWdata;
   logic lastStep;
   logic toggleStill;

   ////////////////////////////////////////////////////////////////////////
   // command sequences as lists of write cycles
   function automatic logic [STEP_W-1:0] seqLen(input fcb_op_t op);
      unique case (op)
         OP_PROGRAM: seqLen = 3'h4;
         OP_BYP_PROGRAM: seqLen = 3'h2;
         OP_ERASE_SECT, OP_ERASE_CHIP: seqLen = 3'h6;
         OP_BYP_ENTER: seqLen = 3'h3;
         OP_BYP_EXIT: seqLen = 3'h2;
         default: seqLen = 3'h1;
      endcase
   endfunction : seqLen

   function automatic fcb_cyc_t seqCycle(input fcb_op_t op,
                                         input logic [STEP_W-1:0] step);
      fcb_cyc_t c;
      c = '{addr: UNLOCK_ADDR_A, data: UNLOCK_DATA_A, fromUser: 1'b0};
      if (op == OP_BYP_PROGRAM) begin
         c = '{addr: '0, data: PROGRAM_CODE, fromUser: 1'b1};
      end else if (op == OP_BYP_EXIT) begin
         c.data = (step == '0) ? BYPASS_EXIT_A : BYPASS_EXIT_B;
      end else if (op == OP_SUSPEND || op == OP_RESUME) begin
         c.data = (op == OP_SUSPEND) ? SUSPEND_CODE : RESUME_CODE;
      end else if (step == 3'h1 || step == 3'h4) begin
         c = '{addr: UNLOCK_ADDR_B, data: UNLOCK_DATA_B, fromUser: 1'b0};
      end else if (step == 3'h2) begin
         unique case (op)
            OP_PROGRAM: c.data = PROGRAM_CODE;
            OP_BYP_ENTER: c.data = BYPASS_CODE;
            default: c.data = ERASE_SETUP_CODE;
         endcase
      end else if (step == 3'h5) begin
         // only the addressed sector is named to the erase
         c.data = (op == OP_ERASE_SECT) ? SECTOR_ERASE_CODE :
            CHIP_ERASE_CODE;
         c.fromUser = (op == OP_ERASE_SECT);
      end
      // last cycle of a program carries the user address and data
      if ((op == OP_PROGRAM && step == 3'h3) ||
          (op == OP_BYP_PROGRAM && step == 3'h1)) begin
         c = '{addr: '0, data: '0, fromUser: 1'b1};
      end
      return c;
   endfunction : seqCycle

   function automatic logic needsWait(input fcb_op_t op);
      needsWait = (op == OP_PROGRAM || op == OP_BYP_PROGRAM ||
                   op == OP_ERASE_SECT || op == OP_ERASE_CHIP ||
                   op == OP_SUSPEND);
   endfunction : needsWait

   ////////////////////////////////////////////////////////////////////////
   // cycle selection
   assign userPinAddr = r_r.byteMode ? r_r.addr[UADDR_W-1:1] :
      r_r.addr[ADDR_W-1:0];
   assign cyc = seqCycle(r_r.op, r_r.step);
   assign cycWrite = !(r_r.isPoll || r_r.op == OP_READ);
   assign cycAddr = (!cycWrite || cyc.fromUser) ? userPinAddr : cyc.addr;
   assign cycLsb = (!cycWrite || cyc.fromUser) ? r_r.addr[0] : 1'b0;
   assign cycStart = (r_r.st == ST_ISSUE);
   assign cycWdata = (lastStep && (r_r.op == OP_PROGRAM ||
      r_r.op == OP_BYP_PROGRAM)) ? r_r.data : cyc.data;
   assign lastStep = (r_r.step == seqLen(r_r.op) - 1'b1);
   assign toggleStill = r_r.havePrev &&
      (r_r.prev[TOGGLE_BIT] == cycRdata[TOGGLE_BIT]);

   fcb_cycle #(
      .SETUP_CYC(AS_CYC),
      .PULSE_CYC(WP_CYC),
      .READ_CYC(ACC_CYC),
      .HOLD_CYC(AH_CYC)
   ) u_cycle (
      .mclk(mclk),
      .rst_b(rst_b),
      .start(cycStart),
      .isWrite(cycWrite),
      .byteMode(r_r.byteMode),
      .byteLsb(cycLsb),
      .addr(cycAddr),
      .wdata(cycWdata),
      .dataIn(flashDataIn),
      .pins(pins),
      .rdata(cycRdata),
      .done(cycDone)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      r_nxt = r_r;
      r_nxt.rbS1 = ready_busy_out;
      r_nxt.rbS2 = r_r.rbS1;
      unique case (r_r.st)
         ST_IDLE: begin
            if (reqValid) begin
               r_nxt.op = reqOp;
               r_nxt.addr = reqAddr;
               r_nxt.data = reqData;
               r_nxt.byteMode = cfgByteMode;
               r_nxt.usePoll = cfgUsePoll;
               r_nxt.step = '0;
               r_nxt.err = 1'b0;
               r_nxt.isPoll = 1'b0;
               r_nxt.havePrev = 1'b0;
               if (reqOp == OP_RESET) begin
                  r_nxt.rstN = 1'b0;
                  r_nxt.cnt = TMO_W'(RP_CYC - 1);
                  r_nxt.st = ST_RSTLO;
               end else if (reqOp == OP_WAIT) begin
                  r_nxt.cnt = TMO_W'(BUSY_CYC - 1);
                  r_nxt.st = ST_SETTLE;
               end else begin
                  r_nxt.st = ST_ISSUE;
               end
            end
         end
         ST_ISSUE: begin
            r_nxt.st = ST_CYC;
         end
         ST_CYC: begin
            if (r_r.isPoll && r_r.cnt != '0) begin
               r_nxt.cnt = r_r.cnt - 1'b1;
            end
            if (cycDone) begin
               if (r_r.op == OP_READ) begin
                  r_nxt.rdData = cycRdata;
                  r_nxt.st = ST_RESP;
               end else if (r_r.isPoll) begin
                  r_nxt.prev = cycRdata;
                  r_nxt.havePrev = 1'b1;
                  if (toggleStill) begin
                     // a blocked program ends with the wrong polling bit
                     r_nxt.rdData = cycRdata;
                     r_nxt.err = (r_r.op == OP_PROGRAM ||
                        r_r.op == OP_BYP_PROGRAM) &&
                        (cycRdata[POLL_BIT] != r_r.data[POLL_BIT]);
                     r_nxt.st = ST_RESP;
                  end else if (r_r.cnt == '0) begin
                     r_nxt.err = 1'b1;
                     r_nxt.st = ST_RESP;
                  end else begin
                     r_nxt.st = ST_ISSUE;
                  end
               end else if (lastStep) begin
                  if (needsWait(r_r.op)) begin
                     // the flash runs the algorithm; only completion is watched
                     r_nxt.cnt = TMO_W'(BUSY_CYC - 1);
                     r_nxt.st = ST_SETTLE;
                  end else begin
                     r_nxt.st = ST_RESP;
                  end
               end else begin
                  r_nxt.step = r_r.step + 1'b1;
                  r_nxt.st = ST_ISSUE;
               end
            end
         end
         ST_SETTLE: begin
            // the busy level needs time to appear after the last write
            if (r_r.cnt == '0) begin
               r_nxt.cnt = TMO_W'(OP_TIMEOUT_CYC);
               r_nxt.isPoll = r_r.usePoll;
               r_nxt.st = r_r.usePoll ? ST_ISSUE : ST_WAITRB;
            end else begin
               r_nxt.cnt = r_r.cnt - 1'b1;
            end
         end
         ST_WAITRB: begin
            if (r_r.rbS2) begin
               r_nxt.st = ST_RESP;
            end else if (r_r.cnt == '0) begin
               r_nxt.err = 1'b1;
               r_nxt.st = ST_RESP;
            end else begin
               r_nxt.cnt = r_r.cnt - 1'b1;
            end
         end
         ST_RSTLO: begin
            // no cycles are issued while the reset pin is low
            if (r_r.cnt == '0) begin
               r_nxt.rstN = 1'b1;
               r_nxt.cnt = TMO_W'(RH_CYC - 1);
               r_nxt.st = ST_RSTREC;
            end else begin
               r_nxt.cnt = r_r.cnt - 1'b1;
            end
         end
         ST_RSTREC: begin
            // an aborted algorithm holds busy until its reset finishes
            if (r_r.cnt != '0) begin
               r_nxt.cnt = r_r.cnt - 1'b1;
            end else if (r_r.rbS2) begin
               r_nxt.st = ST_RESP;
            end
         end
         ST_RESP: begin
            r_nxt.st = ST_IDLE;
         end
         default: begin
            r_nxt.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         r_r <= '{st: ST_IDLE, op: OP_READ, step: '0, addr: '0, data: '0,
                  byteMode: 1'b0, usePoll: 1'b0, isPoll: 1'b0,
                  havePrev: 1'b0, prev: '0, cnt: '0, rbS1: 1'b0,
                  rbS2: 1'b0, err: 1'b0, rdData: '0, rstN: 1'b1};
      end else begin
         r_r <= r_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign reqReady = (r_r.st == ST_IDLE);
   assign busy = (r_r.st != ST_IDLE);
   assign respDone = (r_r.st == ST_RESP);
   assign respErr = r_r.err;
   assign respData = r_r.rdData;
   assign flashReset_n = r_r.rstN;
   assign width_select_pin = ~r_r.byteMode;
   assign flash_chip_select_n = pins.chipSel_n;
   assign flash_output_enable_n = pins.outEn_n;
   assign flash_write_enable_n = pins.wrEn_n;
   assign flashAddr = pins.addr;
   assign flashDataOut = pins.dataOut;
   assign flashDataOe_n = pins.dataOe_n;

endmodule : fcb_host

`default_nettype wire

// ---- tb/fcb_host_assertions.sv ----
// fcb_host_assertions: pin-level properties of the flash bus controller.
// assumes a bind onto fcb_host; one clock, async active-low reset.
`default_nettype none

module fcb_host_assertions
   import fcb_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic reqValid,
   input wire logic reqReady,
   input wire logic respDone,
   input wire logic busy,
   input wire logic flash_chip_select_n,
   input wire logic flash_output_enable_n,
   input wire logic flash_write_enable_n,
   input wire logic flashReset_n,
   input wire logic width_select_pin,
   input wire logic [DATA_W-1:0] flashDataOe_n
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   // counts reset-pin low cycles; too short a pulse may not abort
   logic [7:0] lowCnt_r;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lowCnt_r <= 8'h00;
      end else begin
         lowCnt_r <= flashReset_n ? 8'h00 : lowCnt_r + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   AST_READ_STROBES: assert property (!flash_output_enable_n |->
      flash_write_enable_n && !flash_chip_select_n)
      else $error("read strobe without select or with write");
   AST_WRITE_STROBES: assert property (!flash_write_enable_n |->
      !flash_chip_select_n && flash_output_enable_n)
      else $error("write strobe without select or with read");
   AST_WE_WIDTH: assert property ($fell(flash_write_enable_n) |->
      !flash_write_enable_n [*7] ##1 flash_write_enable_n)
      else $error("write pulse width wrong");
   AST_WORD_WRITE: assert property (!flash_write_enable_n &&
      width_select_pin |-> flashDataOe_n == 16'h0000)
      else $error("word write not on all lanes");
   AST_BYTE_FLOAT: assert property (!width_select_pin &&
      !flash_chip_select_n |-> flashDataOe_n[14:8] == 7'h7F)
      else $error("byte mode drives middle lanes");
   AST_BYTE_TOP: assert property (!width_select_pin &&
      !flash_chip_select_n |-> !flashDataOe_n[15])
      else $error("byte address line not driven");
   AST_READ_FLOAT: assert property (!flash_output_enable_n |->
      flashDataOe_n[14:0] == 15'h7FFF)
      else $error("host drives data during read");
   AST_RST_QUIET: assert property (!flashReset_n |->
      flash_chip_select_n && flash_write_enable_n && flash_output_enable_n)
      else $error("strobes active during reset pulse");
   AST_RST_LEN: assert property ($rose(flashReset_n) |->
      lowCnt_r >= RP_CYC)
      else $error("reset pulse too short");
   AST_TAKE: assert property (reqValid && reqReady |=> busy)
      else $error("request not taken");
   AST_DONE_PULSE: assert property (respDone |=> !respDone)
      else $error("done longer than one cycle");

   COV_WRITE: cover property ($fell(flash_write_enable_n));
   COV_BYTE_READ: cover property (!width_select_pin && !flash_output_enable_n);
   COV_RESET: cover property ($rose(flashReset_n));
endmodule : fcb_host_assertions

bind fcb_host fcb_host_assertions u_chk (.mclk, .rst_b, .reqValid, .reqReady,
   .respDone, .busy, .flash_chip_select_n, .flash_output_enable_n,
   .flash_write_enable_n, .flashReset_n, .width_select_pin, .flashDataOe_n);

`default_nettype wire

// ---- tb/fcb_flash_model.sv ----
// fcb_flash_model: behavioural parallel flash, sixteen words, sector=bit 3.
// assumes the controller's default command words AA/55/A0/80/30/10/B0.
`default_nettype none

module fcb_flash_model
   import fcb_pkg::*;
#(
   parameter int BUSY_NS = 2000
) (
   input wire logic cs_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic rst_n,
   input wire logic wsel,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] hostOut,
   input wire logic [DATA_W-1:0] hostOe_n,
   output logic [DATA_W-1:0] busIn,
   output logic rdy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [16];
   logic [DATA_W-1:0] prevD = '0, tgt = '0, last = '0, word, dev;
   logic armed = 1'b0, tog = 1'b0;
   wire logic rdEn = !cs_n && !oe_n && we_n && rst_n;

   initial begin
      foreach (mem[i]) mem[i] = 16'hFFFF;
      rdy = 1'b1;
   end

   ////////////////////////////////////////
   // writes only latch; the array changes at the end of a sequence
   always @(posedge we_n) begin
      if (!cs_n && rst_n) begin
         if (armed) begin
            mem[addr[3:0]] = mem[addr[3:0]] & busIn;
            tgt = busIn;
            rdy = 1'b0;
         end else if (prevD == 16'h0055 &&
               (busIn == 16'h0030 || busIn == 16'h0010)) begin
            foreach (mem[i]) if (!busIn[5] || i[3] == addr[3])
               mem[i] = 16'hFFFF;
            tgt = 16'hFFFF;
            rdy = 1'b0;
         end else if (busIn == 16'h00B0) begin
            rdy = 1'b1;
         end
         armed = (busIn == 16'h00A0) && !armed;
         prevD = busIn;
      end
   end
   always @(negedge rdy) begin
      #(BUSY_NS);
      rdy = 1'b1;
   end
   always @(negedge rst_n) armed = 1'b0;
   always @(negedge oe_n) if (!rdy) tog = ~tog;
   always @(posedge oe_n) last = busIn;

   assign word = rdy ? mem[addr[3:0]] :
      {tgt[15:8], ~tgt[7], tog, tgt[5:0]};
   assign dev = wsel ? word :
      {8'h00, hostOut[15] ? word[15:8] : word[7:0]};
   // released lanes show the inverse of the last level, never a held value
   always_comb begin
      for (int i = 0; i < DATA_W; i++) begin
         if (!hostOe_n[i]) busIn[i] = hostOut[i];
         else if (rdEn && (wsel || i < BYTE_W))
            busIn[i] = dev[i];
         else busIn[i] = ~last[i];
      end
   end
endmodule : fcb_flash_model

`default_nettype wire

// ---- tb/tb_top.sv ----
// tb_top: sequences of controller requests against the flash model.
// assumes 125 MHz mclk and the model's 2 us busy time.
`default_nettype none

module tb_top
   import fcb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_b, reqValid, cfgByteMode, cfgUsePoll;
   logic reqReady, respDone, respErr, busy, csN, oeN, weN, frstN, wsel, rdy;
   fcb_op_t reqOp;
   logic [UADDR_W-1:0] reqAddr;
   logic [ADDR_W-1:0] fAddr;
   logic [DATA_W-1:0] reqData, respData, fOut, fOe_n, fIn;
   int errTotal = 0, numChecks = 0;
   fcb_op_t ops [5] = '{OP_SUSPEND, OP_RESUME, OP_WAIT, OP_ERASE_CHIP,
      OP_RESET};

   fcb_host #(.OP_TIMEOUT_CYC(2000)) dut (.mclk, .rst_b, .reqValid, .reqReady,
      .reqOp, .reqAddr, .reqData, .cfgByteMode, .cfgUsePoll, .respDone,
      .respErr, .respData, .busy, .flash_chip_select_n(csN),
      .flash_output_enable_n(oeN), .flash_write_enable_n(weN),
      .flashReset_n(frstN), .width_select_pin(wsel), .flashAddr(fAddr),
      .flashDataOut(fOut), .flashDataOe_n(fOe_n), .flashDataIn(fIn),
      .ready_busy_out(rdy));
   fcb_flash_model u_flash (.cs_n(csN), .oe_n(oeN), .we_n(weN), .rst_n(frstN),
      .wsel, .addr(fAddr), .hostOut(fOut), .hostOe_n(fOe_n), .busIn(fIn),
      .rdy);

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   ////////////////////////////////////////
   task automatic endSim();
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : endSim
   task automatic chk(input logic [DATA_W-1:0] got,
         input logic [DATA_W-1:0] exp);
      numChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic req(input fcb_op_t op, input logic [UADDR_W-1:0] a,
         input logic [DATA_W-1:0] d, input logic bm, input logic poll);
      int n = 0;
      @(posedge mclk);
      reqValid <= 1'b1;
      reqOp <= op;
      reqAddr <= a;
      reqData <= d;
      cfgByteMode <= bm;
      cfgUsePoll <= poll;
      @(posedge mclk);
      reqValid <= 1'b0;
      do begin
         @(negedge mclk);
         n++;
      end while (respDone !== 1'b1 && n < 8000);
      if (n >= 8000) begin
         errTotal++;
         endSim();
      end
   endtask : req
   task automatic rdChk(input logic [UADDR_W-1:0] a, input logic bm,
         input logic [DATA_W-1:0] exp);
      req(OP_READ, a, 16'h0000, bm, 1'b0);
      chk(bm ? {8'h00, respData[7:0]} : respData, exp);
   endtask : rdChk

   initial begin
      {rst_b, reqValid, cfgByteMode, cfgUsePoll} = 4'h0;
      reqOp = OP_READ;
      reqAddr = '0;
      reqData = '0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      @(negedge mclk);
      chk({frstN, wsel, csN, oeN, weN, busy, reqReady}, 16'h007D);
      chk(fOe_n, 16'hFFFF);
      $display("test reset done");
      req(OP_PROGRAM, 20'h0_0003, 16'h1234, 1'b0, 1'b0);
      chk(respErr, 16'h0000);
      rdChk(20'h0_0003, 1'b0, 16'h1234);
      req(OP_PROGRAM, 20'h0_0005, 16'h00C3, 1'b0, 1'b1);
      chk(respErr, 16'h0000);
      rdChk(20'h0_0005, 1'b0, 16'h00C3);
      $display("test program done");
      req(OP_BYP_ENTER, 20'h0_0000, 16'h0000, 1'b0, 1'b0);
      req(OP_BYP_PROGRAM, 20'h0_0009, 16'h5A5A, 1'b0, 1'b0);
      req(OP_BYP_EXIT, 20'h0_0000, 16'h0000, 1'b0, 1'b0);
      rdChk(20'h0_0009, 1'b0, 16'h5A5A);
      $display("test bypass done");
      req(OP_ERASE_SECT, 20'h0_0008, 16'h0000, 1'b0, 1'b1);
      rdChk(20'h0_0009, 1'b0, 16'hFFFF);
      rdChk(20'h0_0003, 1'b0, 16'h1234);
      rdChk(20'h0_0007, 1'b1, 16'h0012);
      rdChk(20'h0_0006, 1'b1, 16'h0034);
      chk(wsel, 16'h0000);
      $display("test erase and byte done");
      req(OP_PROGRAM, 20'h0_0003, 16'h0080, 1'b0, 1'b1);
      chk(respErr, 16'h0001);
      foreach (ops[i]) begin
         req(ops[i], 20'h0_0008, 16'h0000, 1'b0, 1'b1);
         chk(respErr, 16'h0000);
      end
      rdChk(20'h0_0003, 1'b0, 16'hFFFF);
      $display("test error and ops done");
      endSim();
   end
endmodule : tb_top

`default_nettype wire
